// [common/dfr_defines.svh]
// timing counts, field positions and constants of the diagnostic fault response block
`ifndef DFR_DEFINES_SVH
`define DFR_DEFINES_SVH

// ----------------------------------------------------------------------------
// clock and self-test timing
// ----------------------------------------------------------------------------
`define DFR_CLK_MHZ 100
`define DFR_LBIST_TIME_MS 200
`define DFR_LBIST_CYCLES (`DFR_LBIST_TIME_MS * 1000 * `DFR_CLK_MHZ)

// ----------------------------------------------------------------------------
// error flag bit positions
// ----------------------------------------------------------------------------
`define DFR_ERR_W 13
`define DFR_ERR_ACF 0
`define DFR_ERR_AOC 1
`define DFR_ERR_TSE 2
`define DFR_ERR_SAT 3
`define DFR_ERR_SLF 4
`define DFR_ERR_SRR 5
`define DFR_ERR_POR 6
`define DFR_ERR_ESE 7
`define DFR_ERR_UVD 8
`define DFR_ERR_OVD 9
`define DFR_ERR_EUE 10
`define DFR_ERR_SPE 11
`define DFR_ERR_OFE 12
`define DFR_CRIT_MASK 13'h1C00

// ----------------------------------------------------------------------------
// self-test signature and scan model
// ----------------------------------------------------------------------------
`define DFR_SIG_GOOD 32'h556E4F7D
`define DFR_SIG_SEED 32'hFFFFFFFF

// ----------------------------------------------------------------------------
// pwm duty codes in tens of percent, zero means no fault
// ----------------------------------------------------------------------------
`define DFR_DUTY_NONE 4'h0
`define DFR_DUTY_SLF 4'h1
`define DFR_DUTY_SRR 4'h2
`define DFR_DUTY_ACF 4'h3
`define DFR_DUTY_TSE 4'h4
`define DFR_DUTY_POR 4'h5
`define DFR_DUTY_UVD 4'h6
`define DFR_DUTY_OVD 4'h7
`define DFR_DUTY_SAT 4'h8
`define DFR_DUTY_AOC 4'h9

`endif

// [common/dfr_pkg.sv]
// types of the diagnostic fault response block
package dfr_pkg;

  typedef enum logic [1:0]
  {
    DFR_DRV_NORMAL = 2'h0,
    DFR_DRV_HIZ = 2'h1,
    DFR_DRV_HIGH = 2'h2,
    DFR_DRV_LOW = 2'h3
  } dfr_drive_e;

  typedef enum logic [2:0]
  {
    DFR_ST_IDLE = 3'h1,
    DFR_ST_RUN = 3'h2,
    DFR_ST_DONE = 3'h4
  } dfr_lbist_e;

endpackage : dfr_pkg

// [core/dfr_lbist.sv]
// logic self-test engine: scan stimulus, signature and verdict
`timescale 1ns/1ps
`include "dfr_defines.svh"

module dfr_lbist #(
  parameter int unsigned RUN_CYCLES = `DFR_LBIST_CYCLES
) (
  // clock and reset
  input wire logic clock_i,
  input wire logic rst_i,
  // control
  input wire logic start_i,
  input wire logic [31:0] scan_data_i,
  // result
  output logic busy_o,
  output logic done_o,
  output logic pass_o,
  output logic [31:0] signature_o
);

  dfr_pkg::dfr_lbist_e state_q;
  dfr_pkg::dfr_lbist_e state_d;
  logic [31:0] cnt_q;
  logic [31:0] lfsr_q;
  logic [31:0] sig_q;
  logic done_q;
  logic pass_q;

  // ----------------------------------------------------------------------------
  // stimulus and signature
  // ----------------------------------------------------------------------------
  // stimulus lfsr feeds the scan chain, response folded into a misr
  wire lfsr_fb = lfsr_q[31] ^ lfsr_q[21] ^ lfsr_q[1] ^ lfsr_q[0];
  wire [31:0] lfsr_nxt = {lfsr_q[30:0], lfsr_fb};
  wire [31:0] misr_nxt = {sig_q[30:0], sig_q[31] ^ sig_q[21] ^ sig_q[1] ^ sig_q[0]} ^ (scan_data_i ^ lfsr_q);
  wire last_cycle = (cnt_q == RUN_CYCLES - 1);

  always_comb
  begin
    state_d = state_q;
    unique case (state_q)
      dfr_pkg::DFR_ST_IDLE: if (start_i) state_d = dfr_pkg::DFR_ST_RUN;
      dfr_pkg::DFR_ST_RUN: if (last_cycle) state_d = dfr_pkg::DFR_ST_DONE;
      dfr_pkg::DFR_ST_DONE: if (start_i) state_d = dfr_pkg::DFR_ST_RUN;
      default: state_d = dfr_pkg::DFR_ST_IDLE;
    endcase
  end

  always_ff @(posedge clock_i)
  begin
    if (rst_i)
    begin
      state_q <= dfr_pkg::DFR_ST_IDLE;
      cnt_q <= 32'h0;
      lfsr_q <= `DFR_SIG_SEED;
      sig_q <= 32'h0;
      done_q <= 1'b0;
      pass_q <= 1'b0;
    end
    else
    begin
      state_q <= state_d;
      if (state_q != dfr_pkg::DFR_ST_RUN && state_d == dfr_pkg::DFR_ST_RUN)
      begin
        cnt_q <= 32'h0;
        lfsr_q <= `DFR_SIG_SEED;
        sig_q <= 32'h0;
        done_q <= 1'b0;
        pass_q <= 1'b0;
      end
      else if (state_q == dfr_pkg::DFR_ST_RUN)
      begin
        cnt_q <= cnt_q + 32'h1;
        lfsr_q <= lfsr_nxt;
        sig_q <= misr_nxt;
        if (last_cycle)
        begin
          done_q <= 1'b1;
          pass_q <= (misr_nxt == `DFR_SIG_GOOD);
        end
      end
    end
  end

  assign busy_o = (state_q == dfr_pkg::DFR_ST_RUN);
  assign done_o = done_q;
  assign pass_o = pass_q;
  assign signature_o = sig_q;

endmodule : dfr_lbist

// [core/dfr_diag.sv]
// diagnostic top: self-test control and fault flag response encoding
`timescale 1ns/1ps
`include "dfr_defines.svh"

// How it works
// - unlocked go write starts the self-test
// - scan stimulus, signature compared with good value
// - self-test runs the fixed 200 ms count
// - link requests ignored while test runs
// - done bit set at end regardless
// - pass bit set only on signature match
// - signature readable after the run
// - five internal flags set status bit zero
// - saturation, clamp set status one, diag 6/7
// - overvoltage sets status one, diag bit five
// - pwm fault codes 10 to 80 percent
// - clamp fault gives pwm 90 percent
// - undervoltage drives hiz, high or low
// - sent restarts when the undervoltage flag clears
// - status one in first frames after undervoltage
// - diag bit five in first frame after undervoltage
// - select set: fault in next enhanced message
// - overvoltage forces hiz when access select 0X
// - filter init may report power-on code
// - undervoltage response ignores the hiz select
// - pwm sends highest priority fault only
// - critical faults latch until power-on reset
module dfr_diag #(
  parameter int unsigned LBIST_CYCLES = `DFR_LBIST_CYCLES
) (
  // clock and reset
  input wire logic clock_i,
  input wire logic rst_i,
  // programming link
  input wire logic unlocked_i,
  input wire logic lbist_go_i,
  input wire logic link_req_i,
  // self-test scan response
  input wire logic [31:0] scan_data_i,
  // configuration
  input wire logic sent_mode_i,
  input wire logic fault_hiz_sel_i,
  input wire logic [1:0] lowvolt_response_select_i,
  input wire logic [1:0] access_sel_i,
  input wire logic [3:0] err_min_frames_i,
  // fault detectors
  input wire logic [12:0] flags_i,
  input wire logic filter_init_i,
  // frame timing from the generators
  input wire logic frame_start_i,
  input wire logic enh_msg_start_i,
  // self-test results
  output logic lbist_busy_o,
  output logic lbist_done_o,
  output logic lbist_pass_o,
  output logic [31:0] lbist_signature_o,
  output logic link_ack_o,
  // fault response
  output logic [12:0] error_flags_o,
  output logic [1:0] sent_status_bits_o,
  output logic [7:0] diag_byte_o,
  output logic pwm_half_freq_o,
  output logic [3:0] pwm_duty_code_o,
  output logic [1:0] drive_o,
  output logic [12:0] enh_flags_o,
  output logic sent_restart_o
);

  // ----------------------------------------------------------------------------
  // input synchronisers
  // ----------------------------------------------------------------------------
  logic [17:0] sync1_q;
  logic [17:0] sync2_q;
  wire [17:0] raw_in = {lbist_go_i, link_req_i, filter_init_i, unlocked_i, flags_i, 1'b0};

  always_ff @(posedge clock_i)
  begin
    if (rst_i)
    begin
      sync1_q <= 18'h0;
      sync2_q <= 18'h0;
    end
    else
    begin
      sync1_q <= raw_in;
      sync2_q <= sync1_q;
    end
  end

  wire go_s = sync2_q[17];
  wire req_s = sync2_q[16];
  wire finit_s = sync2_q[15];
  wire unl_s = sync2_q[14];
  wire [12:0] flags_s = sync2_q[13:1];
  // frame strobes come from on-chip generators on this clock, no sync needed

  // ----------------------------------------------------------------------------
  // self-test control
  // ----------------------------------------------------------------------------
  logic go_d1_q;
  logic busy;
  logic done;
  logic pass;
  logic [31:0] sig;
  logic link_ack_q;

  always_ff @(posedge clock_i)
  begin
    if (rst_i)
      go_d1_q <= 1'b0;
    else
      go_d1_q <= go_s;
  end

  // go write is a rising level seen only while unlocked
  wire go_write = go_s & ~go_d1_q & unl_s & ~busy;

  dfr_lbist #(
    .RUN_CYCLES(LBIST_CYCLES)
  ) u_lbist (
    .clock_i(clock_i),
    .rst_i(rst_i),
    .start_i(go_write),
    .scan_data_i(scan_data_i),
    .busy_o(busy),
    .done_o(done),
    .pass_o(pass),
    .signature_o(sig)
  );

  logic lb_busy_q;
  logic lb_done_q;
  logic lb_pass_q;
  logic [31:0] lb_sig_q;

  always_ff @(posedge clock_i)
  begin
    if (rst_i)
    begin
      lb_busy_q <= 1'b0;
      lb_done_q <= 1'b0;
      lb_pass_q <= 1'b0;
      lb_sig_q <= 32'h0;
      link_ack_q <= 1'b0;
    end
    else
    begin
      lb_busy_q <= busy;
      lb_done_q <= done;
      lb_pass_q <= pass;
      lb_sig_q <= sig;
      link_ack_q <= req_s & ~busy & ~go_write;
    end
  end

  // ----------------------------------------------------------------------------
  // error flag capture
  // ----------------------------------------------------------------------------
  // critical bits hold until reset; others follow the detector but are held
  // until reported so a short event still reaches one frame
  logic [12:0] err_q;
  logic [12:0] enh_q;
  logic [12:0] pend_q;
  wire [12:0] crit = `DFR_CRIT_MASK;
  wire [12:0] err_d = (flags_s & ~crit) | (pend_q & ~crit) | ((err_q | flags_s) & crit);

  always_ff @(posedge clock_i)
  begin
    if (rst_i)
      err_q <= 13'h0;
    else
      err_q <= err_d;
  end

  // flags raised since the last report; a new event wins over the report clear
  wire report_evt = sent_mode_i ? frame_start_i : frame_start_i;

  always_ff @(posedge clock_i)
  begin
    if (rst_i)
      pend_q <= 13'h0;
    else if (report_evt)
      pend_q <= flags_s;
    else
      pend_q <= pend_q | flags_s;
  end

  // enhanced copy only refreshes when the next enhanced message begins
  always_ff @(posedge clock_i)
  begin
    if (rst_i)
      enh_q <= 13'h0;
    else if (enh_msg_start_i)
      enh_q <= err_d;
  end

  // ----------------------------------------------------------------------------
  // undervoltage exit tracking
  // ----------------------------------------------------------------------------
  wire uv = err_q[`DFR_ERR_UVD];
  logic uv_d1_q;
  logic [3:0] uv_frames_q;
  logic uv_first_q;
  logic restart_q;

  wire uv_exit = uv_d1_q & ~uv;

  always_ff @(posedge clock_i)
  begin
    if (rst_i)
    begin
      uv_d1_q <= 1'b0;
      uv_frames_q <= 4'h0;
      uv_first_q <= 1'b0;
      restart_q <= 1'b0;
    end
    else
    begin
      uv_d1_q <= uv;
      restart_q <= uv_exit & sent_mode_i;
      if (uv_exit)
      begin
        uv_first_q <= 1'b1;
        uv_frames_q <= (err_min_frames_i == 4'h0) ? 4'h1 : err_min_frames_i;
      end
      else if (frame_start_i && uv_frames_q != 4'h0)
      begin
        uv_first_q <= 1'b0;
        uv_frames_q <= uv_frames_q - 4'h1;
      end
    end
  end

  // ----------------------------------------------------------------------------
  // sent status and diagnostic byte
  // ----------------------------------------------------------------------------
  wire uv_post = (uv_frames_q != 4'h0);
  wire por_rep = err_q[`DFR_ERR_POR] | finit_s;
  wire st0 = err_q[`DFR_ERR_SLF] | err_q[`DFR_ERR_SRR] | err_q[`DFR_ERR_ACF] | err_q[`DFR_ERR_TSE] | por_rep;
  wire st1 = err_q[`DFR_ERR_OVD] | err_q[`DFR_ERR_SAT] | err_q[`DFR_ERR_AOC] | uv_post;
  wire [7:0] diag = {err_q[`DFR_ERR_AOC], err_q[`DFR_ERR_SAT],
                     err_q[`DFR_ERR_OVD] | uv_first_q,
                     err_q[`DFR_ERR_POR], err_q[`DFR_ERR_TSE], err_q[`DFR_ERR_ACF],
                     err_q[`DFR_ERR_SRR], err_q[`DFR_ERR_SLF]};

  // ----------------------------------------------------------------------------
  // pwm priority encoder
  // ----------------------------------------------------------------------------
  function automatic logic [3:0] pwm_code(input logic [12:0] e, input logic p);
    logic [3:0] c;
    c = `DFR_DUTY_NONE;
    if (e[`DFR_ERR_AOC]) c = `DFR_DUTY_AOC;
    if (e[`DFR_ERR_SAT]) c = `DFR_DUTY_SAT;
    if (e[`DFR_ERR_OVD]) c = `DFR_DUTY_OVD;
    if (e[`DFR_ERR_UVD]) c = `DFR_DUTY_UVD;
    if (p) c = `DFR_DUTY_POR;
    if (e[`DFR_ERR_TSE]) c = `DFR_DUTY_TSE;
    if (e[`DFR_ERR_ACF]) c = `DFR_DUTY_ACF;
    if (e[`DFR_ERR_SRR]) c = `DFR_DUTY_SRR;
    if (e[`DFR_ERR_SLF]) c = `DFR_DUTY_SLF;
    return c;
  endfunction : pwm_code

  wire [3:0] duty = pwm_code(err_q, por_rep);

  // ----------------------------------------------------------------------------
  // output drive selection, highest priority first
  // ----------------------------------------------------------------------------
  wire noncrit_any = |(err_q & ~crit & ~(13'h1 << `DFR_ERR_UVD));
  wire ovd_hiz = err_q[`DFR_ERR_OVD] & ~access_sel_i[1];
  wire [1:0] uv_drive = (lowvolt_response_select_i == 2'h1) ? dfr_pkg::DFR_DRV_HIGH :
                        (lowvolt_response_select_i == 2'h2) ? dfr_pkg::DFR_DRV_LOW : dfr_pkg::DFR_DRV_HIZ;
  wire [1:0] drive = (|(err_q & crit)) ? dfr_pkg::DFR_DRV_HIZ :
                     uv ? uv_drive :
                     ovd_hiz ? dfr_pkg::DFR_DRV_HIZ :
                     (fault_hiz_sel_i & noncrit_any) ? dfr_pkg::DFR_DRV_HIZ :
                     dfr_pkg::DFR_DRV_NORMAL;

  logic [12:0] err_o_q;
  logic [1:0] st_q;
  logic [7:0] diag_q;
  logic half_q;
  logic [3:0] duty_q;
  logic [1:0] drive_q;

  always_ff @(posedge clock_i)
  begin
    if (rst_i)
    begin
      err_o_q <= 13'h0;
      st_q <= 2'h0;
      diag_q <= 8'h0;
      half_q <= 1'b0;
      duty_q <= 4'h0;
      drive_q <= dfr_pkg::DFR_DRV_HIZ;
    end
    else
    begin
      err_o_q <= err_q;
      st_q <= (sent_mode_i & ~fault_hiz_sel_i) ? {st1, st0} : 2'h0;
      diag_q <= (sent_mode_i & ~fault_hiz_sel_i) ? diag : 8'h0;
      half_q <= ~sent_mode_i & ~fault_hiz_sel_i & (duty != `DFR_DUTY_NONE);
      duty_q <= (~sent_mode_i & ~fault_hiz_sel_i) ? duty : `DFR_DUTY_NONE;
      drive_q <= drive;
    end
  end

  assign lbist_busy_o = lb_busy_q;
  assign lbist_done_o = lb_done_q;
  assign lbist_pass_o = lb_pass_q;
  assign lbist_signature_o = lb_sig_q;
  assign link_ack_o = link_ack_q;
  assign error_flags_o = err_o_q;
  assign sent_status_bits_o = st_q;
  assign diag_byte_o = diag_q;
  assign pwm_half_freq_o = half_q;
  assign pwm_duty_code_o = duty_q;
  assign drive_o = drive_q;
  assign enh_flags_o = enh_q;
  assign sent_restart_o = restart_q;

  // ----------------------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------------------
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (rst_i);

  AST_GO_STARTS: assert property (go_write |=> busy ##1 lbist_busy_o)
    else $error("self-test did not start on go write");
  AST_NO_LINK_BUSY: assert property (busy |=> !link_ack_o)
    else $error("link answered during self-test");
  AST_DONE_SET: assert property ($fell(busy) |=> lbist_done_o)
    else $error("done bit not set at end");
  AST_PASS_MATCH: assert property ($rose(done) |-> pass == (sig == `DFR_SIG_GOOD))
    else $error("pass bit disagrees with signature");
  AST_CRIT_LATCH: assert property (err_q[`DFR_ERR_OFE] |=> err_q[`DFR_ERR_OFE])
    else $error("critical flag cleared without reset");
  AST_CRIT_HIZ: assert property (|(err_q & crit) |=> drive_o == dfr_pkg::DFR_DRV_HIZ)
    else $error("critical fault not high impedance");
  AST_PWM_SLF: assert property (!sent_mode_i && !fault_hiz_sel_i && err_q[`DFR_ERR_SLF]
    |=> pwm_duty_code_o == `DFR_DUTY_SLF && pwm_half_freq_o)
    else $error("top priority pwm code not sent");
  AST_SENT_ST1: assert property (sent_mode_i && !fault_hiz_sel_i && err_q[`DFR_ERR_SAT]
    |=> sent_status_bits_o[1] && diag_byte_o[6])
    else $error("saturation not reported in sent");
  AST_UV_FIRST: assert property (uv_exit |=> uv_first_q)
    else $error("undervoltage exit not flagged");

  COV_LBIST_DONE: cover property ($rose(lbist_done_o));
  COV_PWM_FAULT: cover property (pwm_half_freq_o);
  COV_UV_EXIT: cover property (uv_exit);

endmodule : dfr_diag

// [verif/dfr_ctrl_model.sv]
// controller-side model: frame and enhanced message timing seen by the encoder
`timescale 1ns/1ps
module dfr_ctrl_model #(
  parameter int unsigned FRAME = 16,
  parameter int unsigned ENH = 4
) (
  // clock and reset
  input wire logic clock_i,
  input wire logic rst_i,
  // frame timing
  output logic frame_start_o,
  output logic enh_msg_start_o
);
  logic [7:0] cyc_q;
  logic [3:0] frm_q;
  wire wrap = (cyc_q == 8'(FRAME - 1));
  wire last = (frm_q == 4'(ENH - 1));

  // a longer FRAME models a slow receiver; frames never overlap
  always_ff @(posedge clock_i)
  begin
    if (rst_i)
    begin
      cyc_q <= 8'h00;
      frm_q <= 4'h0;
      frame_start_o <= 1'b0;
      enh_msg_start_o <= 1'b0;
    end
    else
    begin
      cyc_q <= wrap ? 8'h00 : cyc_q + 8'h01;
      frm_q <= wrap ? (last ? 4'h0 : frm_q + 4'h1) : frm_q;
      frame_start_o <= wrap;
      // enhanced message starts only once the previous one has run its frames
      enh_msg_start_o <= wrap && last;
    end
  end
endmodule : dfr_ctrl_model

// [verif/test_dfr_diag.sv]
// self-checking testbench of the diagnostic fault response block
`timescale 1ns/1ps
`include "dfr_defines.svh"
module test_dfr_diag;
  logic clock_i = 1'b0;
  logic rst_i = 1'b1;
  logic unlocked_i = 1'b0;
  logic lbist_go_i = 1'b0;
  logic link_req_i = 1'b0;
  logic [31:0] scan_data_i = 32'h0;
  logic sent_mode_i = 1'b0;
  logic fault_hiz_sel_i = 1'b0;
  logic [1:0] lowvolt_response_select_i = 2'h0;
  logic [1:0] access_sel_i = 2'h2;
  logic [12:0] flags_i = 13'h0;
  logic filter_init_i = 1'b0;
  logic [3:0] err_min_frames_i = 4'h1;
  logic frame_start_i;
  logic enh_msg_start_i;
  logic lbist_busy_o, lbist_done_o, lbist_pass_o, link_ack_o;
  logic pwm_half_freq_o, sent_restart_o;
  logic [31:0] lbist_signature_o;
  logic [12:0] error_flags_o, enh_flags_o;
  logic [1:0] sent_status_bits_o, drive_o;
  logic [7:0] diag_byte_o;
  logic [3:0] pwm_duty_code_o;
  integer seed = 64;
  int n_errors = 0;
  int total_checks = 0;
  int k;
  int nf;
  int ord[9] = '{4, 5, 0, 2, 6, 8, 9, 3, 1};
  int dmap[8] = '{4, 5, 0, 2, 6, 9, 3, 1};

  always #5 clock_i = ~clock_i;
  always @(negedge clock_i) scan_data_i <= $random(seed);

  dfr_diag #(.LBIST_CYCLES(50)) dfr_diag_i (.clock_i(clock_i), .rst_i(rst_i),
    .unlocked_i(unlocked_i), .lbist_go_i(lbist_go_i), .link_req_i(link_req_i),
    .scan_data_i(scan_data_i), .sent_mode_i(sent_mode_i), .fault_hiz_sel_i(fault_hiz_sel_i),
    .lowvolt_response_select_i(lowvolt_response_select_i), .access_sel_i(access_sel_i),
    .err_min_frames_i(err_min_frames_i), .flags_i(flags_i), .filter_init_i(filter_init_i),
    .frame_start_i(frame_start_i), .enh_msg_start_i(enh_msg_start_i),
    .lbist_busy_o(lbist_busy_o), .lbist_done_o(lbist_done_o), .lbist_pass_o(lbist_pass_o),
    .lbist_signature_o(lbist_signature_o), .link_ack_o(link_ack_o),
    .error_flags_o(error_flags_o), .sent_status_bits_o(sent_status_bits_o),
    .diag_byte_o(diag_byte_o), .pwm_half_freq_o(pwm_half_freq_o),
    .pwm_duty_code_o(pwm_duty_code_o), .drive_o(drive_o), .enh_flags_o(enh_flags_o),
    .sent_restart_o(sent_restart_o));

  dfr_ctrl_model dfr_ctrl_model_i (.clock_i(clock_i), .rst_i(rst_i),
    .frame_start_o(frame_start_i), .enh_msg_start_o(enh_msg_start_i));

  // ---------------------------------------------------------------------------
  // expectations and checks
  // ---------------------------------------------------------------------------
  function automatic logic [3:0] exp_duty(input logic [12:0] f);
    logic [3:0] d;
    d = 4'h0;
    // walk from lowest priority so the highest one present wins
    for (int i = 8; i >= 0; i--) if (f[ord[i]]) d = 4'(i + 1);
    return d;
  endfunction : exp_duty

  function automatic logic [7:0] exp_diag(input logic [12:0] f);
    logic [7:0] d;
    for (int j = 0; j < 8; j++) d[j] = f[dmap[j]];
    return d;
  endfunction : exp_diag

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp)
    begin
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      n_errors++;
    end
  endtask : chk

  task automatic test_done();
    $display("checks=%0d mismatches=%0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : test_done

  task automatic run(input logic [12:0] f, input logic s, input logic h, input logic [1:0] a);
    logic [1:0] dr;
    dr = ((h && (|f)) || (f[9] && !a[1])) ? 2'h1 : 2'h0;
    flags_i = f;
    sent_mode_i = s;
    fault_hiz_sel_i = h;
    access_sel_i = a;
    repeat (6) @(negedge clock_i);
    chk(error_flags_o, f);
    chk(drive_o, dr);
    if (s && !h)
    begin
      chk(sent_status_bits_o, {|(f & 13'h030A), |(f & 13'h0075)});
      chk(diag_byte_o, exp_diag(f));
    end
    if (!s && !h && dr == 2'h0)
    begin
      chk(pwm_duty_code_o, exp_duty(f));
      chk(pwm_half_freq_o, |exp_duty(f));
    end
    flags_i = 13'h0;
    repeat (40) @(negedge clock_i);
    chk(drive_o, 2'h0);
  endtask : run

  initial
  begin
    // the whole sequence needs well under 10000 cycles
    #100us;
    n_errors++;
    test_done();
  end

  // ---------------------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------------------
  initial
  begin
    repeat (10) @(negedge clock_i);
    chk(drive_o, 2'h1);
    chk(lbist_done_o, 1'b0);
    rst_i = 1'b0;
    unlocked_i = 1'b1;
    repeat (6) @(negedge clock_i);
    chk(drive_o, 2'h0);
    lbist_go_i = 1'b1;
    k = 0;
    while (lbist_busy_o !== 1'b1 && k < 10) begin @(negedge clock_i); k++; end
    chk(lbist_busy_o, 1'b1);
    link_req_i = 1'b1;
    repeat (5) @(negedge clock_i);
    chk(link_ack_o, 1'b0);
    k = 0;
    while (lbist_done_o !== 1'b1 && k < 200) begin @(negedge clock_i); k++; end
    chk(k >= 40 && k <= 55, 1'b1);
    chk(lbist_done_o, 1'b1);
    chk(lbist_busy_o, 1'b0);
    chk(lbist_pass_o, lbist_signature_o === `DFR_SIG_GOOD);
    repeat (4) @(negedge clock_i);
    chk(link_ack_o, 1'b1);
    lbist_go_i = 1'b0;
    link_req_i = 1'b0;
    $display("test lbist finished");
    for (int b = 0; b < 10; b++)
      if (b != 8)
        for (int m = 0; m < 3; m++)
          run(13'(1) << b, m[0], m[1], 2'h2);
    repeat (30)
      run(13'($random(seed)) & 13'h02FF, 1'($random(seed)), 1'($random(seed)), 2'($random(seed)));
    $display("test flag mapping finished");
    for (int u = 0; u < 8; u++)
    begin
      lowvolt_response_select_i = u[1:0];
      fault_hiz_sel_i = u[0];
      sent_mode_i = u[2];
      flags_i = 13'h0100;
      repeat (6) @(negedge clock_i);
      chk(drive_o, (u[1:0] == 2'h1) ? 2'h2 : (u[1:0] == 2'h2) ? 2'h3 : 2'h1);
      flags_i = 13'h0;
      err_min_frames_i = 4'(u[1:0]);
      k = 0;
      nf = 0;
      // long enough for three report frames after the undervoltage exit
      repeat (80)
      begin
        @(negedge clock_i);
        if (frame_start_i === 1'b1 && sent_status_bits_o[1] === 1'b1) nf++;
        if (sent_restart_o === 1'b1) k = k | 1;
        if (drive_o === 2'h0 && sent_status_bits_o[1] === 1'b1) k = k | 2;
        if (drive_o === 2'h0 && diag_byte_o[5] === 1'b1) k = k | 4;
      end
      if (u[2]) chk(k[0], 1'b1);
      if (u[2] && !u[0]) chk(k[2:1], 2'h3);
      if (u[2] && !u[0]) chk(nf, (u[1:0] == 2'h0) ? 1 : u[1:0]);
      repeat (40) @(negedge clock_i);
    end
    $display("test undervoltage finished");
    fault_hiz_sel_i = 1'b1;
    flags_i = 13'h0008;
    k = 0;
    repeat (300) begin @(negedge clock_i); if (enh_msg_start_i === 1'b1 && k < 2) k++; end
    chk(enh_flags_o[3], 1'b1);
    flags_i = 13'h0;
    fault_hiz_sel_i = 1'b0;
    repeat (40) @(negedge clock_i);
    $display("test enhanced message finished");
    sent_mode_i = 1'b0;
    filter_init_i = 1'b1;
    repeat (6) @(negedge clock_i);
    chk(pwm_duty_code_o, `DFR_DUTY_POR);
    chk(pwm_half_freq_o, 1'b1);
    sent_mode_i = 1'b1;
    repeat (2) @(negedge clock_i);
    chk(sent_status_bits_o, 2'h1);
    filter_init_i = 1'b0;
    repeat (6) @(negedge clock_i);
    chk(sent_status_bits_o, 2'h0);
    $display("test filter init finished");
    for (int b = 10; b < 13; b++)
    begin
      sent_mode_i = b[0];
      flags_i = 13'(1) << b;
      repeat (6) @(negedge clock_i);
      chk(drive_o, 2'h1);
      flags_i = 13'h0;
      repeat (40) @(negedge clock_i);
      chk(drive_o, 2'h1);
      rst_i = 1'b1;
      repeat (2) @(negedge clock_i);
      rst_i = 1'b0;
      repeat (6) @(negedge clock_i);
      chk(drive_o, 2'h0);
    end
    $display("test critical faults finished");
    test_done();
  end
endmodule : test_dfr_diag
